// [hdl/idt_pkg.sv]
// Purpose: Shared constants and carriers for the diagnostic and timing select registers.
// Assumes: Classic Wishbone slave with 32-bit data, one register per aligned word.
// Notes: Printed offsets are register indices; byte address is four times the index.
package idt_pkg;

	// ------------------------------------------------------------
	// Register indices and bus geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 14;
	localparam logic [11:0] IDX_LINK_SEL = 12'h409;
	localparam logic [11:0] IDX_ANOMALY = 12'h40b;
	localparam logic [11:0] IDX_ADDR_PROBE = 12'h40e;
	localparam logic [11:0] IDX_SCRATCH = 12'h40f;
	localparam logic [11:0] IDX_TIM_INDEX = 12'h410;
	localparam logic [11:0] IDX_TIM_DATA = 12'h411;
	localparam logic [11:0] IDX_IRQ_STATUS = 12'h420;
	localparam logic [11:0] IDX_IRQ_MASK = 12'h421;
	localparam int PROBE_BITS = 10;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int LINK_MSB = 4;
	localparam int TIM_TYPE_MSB = 7;
	localparam int TIM_TYPE_LSB = 6;
	localparam int TIM_ID_MSB = 3;
	localparam int TIM_SRC_MSB = 5;
	localparam logic [7:0] SCRATCH_RST = 8'h00;
	localparam logic [7:0] TIM_INDEX_RST = 8'h00;
	localparam logic [7:0] TIM_INDEX_MASK = 8'hcf;
	localparam logic [7:0] TIM_DATA_MASK = 8'h3f;
	localparam logic [5:0] SRC_PORT_MAX = 6'h1f;
	localparam logic [5:0] SRC_SYSCLK = 6'h20;
	localparam logic [5:0] SRC_REFCLK = 6'h21;
	localparam logic [5:0] SRC_8K = 6'h22;
	localparam logic [3:0] GROUP_MAX = 4'hf;
	localparam logic [3:0] TRL_MAX = 4'h1;
	localparam int NUM_GROUPS = 16;
	localparam int NUM_TRL = 2;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		TIM_RX_REF,
		TIM_TX_REF,
		TIM_TRL_OUT,
		TIM_CLK_DIV
	} idt_tim_type_e;

	typedef struct packed
	{
		logic icpErr;
		logic unexpLabel;
		logic unexpLid;
		logic unexpGroupId;
		logic unexpM;
		logic unexpFrame;
		logic unexpOffset;
		logic icpMis;
	} idt_anomaly_s;

	typedef struct packed
	{
		logic [4:0] port;
		idt_anomaly_s events;
	} idt_link_event_s;

	typedef enum logic [1:0]
	{
		BUS_IDLE,
		BUS_ACK
	} idt_bus_e;

endpackage

// [hdl/idt_diag_timing_regs.sv]
// Purpose: Link anomaly flags, address line probe, scratch register, and indirect timing selection.
// Assumes: One clock at 20 MHz, synchronous active-low reset, anomaly events on the same clock.
// Notes: Ack comes one cycle after a request is seen and falls the cycle after.
//
// Contract
// [R1] Anomaly flags only follow the link chosen by the link select register.
// [R2] Anomaly flags are read-only and clear when the host reads them, except a flag whose event coincides with the read.
// [R3] Bit 7 latches an errored control-cell anomaly until read.
// [R4] Bit 6 latches the unexpected label condition until read.
// [R5] Bit 5 latches unexpected link id, bit 4 unexpected group id.
// [R6] Bits 3, 2, 1 latch unexpected M, frame number and cell offset.
// [R7] Bit 0 latches a missing control-cell anomaly until read.
// [R8] Probe bit 0 is XOR of ten address bits of the previous access.
// [R9] Scratch register is 8-bit read/write, resets to zero, drives nothing.
// [R10] Index register selects the element that the data register then configures.
// [R11] Type field bits 7..6 selects rx ref, tx ref, output source or divisor.
// [R12] For types 0, 1, 3 the id bits 3..0 select a group.
// [R13] For type 2 id values 0 and 1 select output pin 0 or 1.
// [R14] Host writes zero to reserved index bits 5 and 4.
// [R15] Link select holds a 5-bit port address 0x00 to 0x1f.
// [R16] For types 0 and 1, data 0x00-0x1f port, 0x20 sysclk, 0x21 refclk.
// [R17] An event coinciding with a clearing read stays set after the read.
// [R18] Probe bit updates on every access and resets to zero.
//
// Chosen here: the Wishbone slave port.
module idt_diag_timing_regs
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Wishbone slave
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [idt_pkg::ADDR_W-1:0] wbAdr,
	input wire logic [3:0] wbSel,
	input wire logic [31:0] wbDatW,
	output logic [31:0] wbDatR,
	output logic wbAck,
	// Anomaly events from the receive links
	input wire idt_pkg::idt_link_event_s linkEvent,
	// Selected diagnostic link and timing configuration
	output logic [4:0] diagPort,
	output logic [5:0] rxGroupSrc [idt_pkg::NUM_GROUPS],
	output logic [5:0] txGroupSrc [idt_pkg::NUM_GROUPS],
	output logic [3:0] groupClkDiv [idt_pkg::NUM_GROUPS],
	output logic [5:0] trlOutSrc [idt_pkg::NUM_TRL],
	// Interrupt
	output logic irq
);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic req;
	logic [11:0] idx;
	logic wrLane;
	logic rdAnomaly;
	logic wrEn;
	logic [7:0] wrByte;
	idt_pkg::idt_bus_e busState_reg;

	assign idx = wbAdr[idt_pkg::ADDR_W-1:2];
	assign req = wbCyc && wbStb && (busState_reg == idt_pkg::BUS_IDLE);
	assign wrLane = wbSel[0];
	assign wrEn = req && wbWe && wrLane;
	assign wrByte = wbDatW[7:0];
	assign rdAnomaly = req && !wbWe && (idx == idt_pkg::IDX_ANOMALY);

	always_ff @(posedge clk)
	begin
		if (!rstn)
			busState_reg <= idt_pkg::BUS_IDLE;
		else
		begin
			case (busState_reg)
				idt_pkg::BUS_IDLE:
					if (wbCyc && wbStb)
						busState_reg <= idt_pkg::BUS_ACK;
				idt_pkg::BUS_ACK:
					busState_reg <= idt_pkg::BUS_IDLE;
				default:
					busState_reg <= idt_pkg::BUS_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Link select and anomaly flags
	// ------------------------------------------------------------
	logic [4:0] linkSel_reg;
	idt_pkg::idt_anomaly_s anomaly_reg;
	idt_pkg::idt_anomaly_s anomalyHit;

	always_ff @(posedge clk)
	begin
		if (!rstn)
			linkSel_reg <= '0;
		else if (wrEn && idx == idt_pkg::IDX_LINK_SEL)
			linkSel_reg <= wrByte[idt_pkg::LINK_MSB:0]; // [R15]
	end

	// Events from other links are ignored.
	assign anomalyHit = (linkEvent.port == linkSel_reg) ? linkEvent.events : '0; // [R1]

	always_ff @(posedge clk)
	begin
		if (!rstn)
			anomaly_reg <= '0;
		else if (rdAnomaly)
			anomaly_reg <= anomalyHit; // [R2] [R17]
		else
			anomaly_reg <= anomaly_reg | anomalyHit; // [R3] [R4] [R5] [R6] [R7]
	end

	// ------------------------------------------------------------
	// Address probe and scratch
	// ------------------------------------------------------------
	logic probe_reg;
	logic [7:0] scratch_reg;

	always_ff @(posedge clk)
	begin
		if (!rstn)
			probe_reg <= 1'b0; // [R18]
		else if (req)
			probe_reg <= ^wbAdr[idt_pkg::PROBE_BITS+1:2]; // [R8] [R18]
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			scratch_reg <= idt_pkg::SCRATCH_RST; // [R9]
		else if (wrEn && idx == idt_pkg::IDX_SCRATCH)
			scratch_reg <= wrByte; // [R9]
	end

	// ------------------------------------------------------------
	// Indirect timing selection
	// ------------------------------------------------------------
	logic [7:0] timIndex_reg;
	idt_pkg::idt_tim_type_e timType;
	logic [3:0] timId;
	logic wrTimData;
	logic [5:0] srcByte;
	logic [5:0] timReadback;

	always_ff @(posedge clk)
	begin
		if (!rstn)
			timIndex_reg <= idt_pkg::TIM_INDEX_RST;
		else if (wrEn && idx == idt_pkg::IDX_TIM_INDEX)
			timIndex_reg <= wrByte & idt_pkg::TIM_INDEX_MASK; // [R10] [R14]
	end

	assign timType = idt_pkg::idt_tim_type_e'(
		timIndex_reg[idt_pkg::TIM_TYPE_MSB:idt_pkg::TIM_TYPE_LSB]); // [R11]
	assign timId = timIndex_reg[idt_pkg::TIM_ID_MSB:0]; // [R12]
	assign wrTimData = wrEn && idx == idt_pkg::IDX_TIM_DATA; // [R10]
	assign srcByte = wrByte[idt_pkg::TIM_SRC_MSB:0];

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			rxGroupSrc <= '{default: '0};
			txGroupSrc <= '{default: '0};
			groupClkDiv <= '{default: '0};
			trlOutSrc <= '{default: '0};
		end
		else if (wrTimData)
		begin
			case (timType)
				idt_pkg::TIM_RX_REF:
					if (srcByte <= idt_pkg::SRC_REFCLK)
						rxGroupSrc[timId] <= srcByte; // [R12] [R16]
				idt_pkg::TIM_TX_REF:
					if (srcByte <= idt_pkg::SRC_REFCLK)
						txGroupSrc[timId] <= srcByte; // [R12] [R16]
				idt_pkg::TIM_TRL_OUT:
					if (timId <= idt_pkg::TRL_MAX && srcByte <= idt_pkg::SRC_8K)
						trlOutSrc[timId[0]] <= srcByte; // [R13]
				idt_pkg::TIM_CLK_DIV:
					groupClkDiv[timId] <= wrByte[idt_pkg::TIM_ID_MSB:0]; // [R12]
				default:
					;
			endcase
		end
	end

	always_comb
	begin
		case (timType)
			idt_pkg::TIM_RX_REF: timReadback = rxGroupSrc[timId];
			idt_pkg::TIM_TX_REF: timReadback = txGroupSrc[timId];
			idt_pkg::TIM_TRL_OUT: timReadback = trlOutSrc[timId[0]];
			idt_pkg::TIM_CLK_DIV: timReadback = {2'h0, groupClkDiv[timId]};
			default: timReadback = '0;
		endcase
	end

	// ------------------------------------------------------------
	// Interrupt status and mask
	// ------------------------------------------------------------
	logic [7:0] irqStatus_reg;
	logic [7:0] irqMask_reg;

	always_ff @(posedge clk)
	begin
		if (!rstn)
			irqMask_reg <= '0;
		else if (wrEn && idx == idt_pkg::IDX_IRQ_MASK)
			irqMask_reg <= wrByte;
	end

	// Set wins over a write-one clear in the same cycle.
	always_ff @(posedge clk)
	begin
		if (!rstn)
			irqStatus_reg <= '0;
		else if (wrEn && idx == idt_pkg::IDX_IRQ_STATUS)
			irqStatus_reg <= (irqStatus_reg & ~wrByte) | anomalyHit;
		else
			irqStatus_reg <= irqStatus_reg | anomalyHit;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			irq <= 1'b0;
		else
			irq <= |(irqStatus_reg & irqMask_reg);
	end

	// ------------------------------------------------------------
	// Read data and acknowledge
	// ------------------------------------------------------------
	logic [7:0] rdByte;

	always_comb
	begin
		case (idx)
			idt_pkg::IDX_LINK_SEL: rdByte = {3'h0, linkSel_reg};
			idt_pkg::IDX_ANOMALY: rdByte = anomaly_reg;
			idt_pkg::IDX_ADDR_PROBE: rdByte = {7'h00, probe_reg};
			idt_pkg::IDX_SCRATCH: rdByte = scratch_reg;
			idt_pkg::IDX_TIM_INDEX: rdByte = timIndex_reg;
			idt_pkg::IDX_TIM_DATA: rdByte = {2'h0, timReadback};
			idt_pkg::IDX_IRQ_STATUS: rdByte = irqStatus_reg;
			idt_pkg::IDX_IRQ_MASK: rdByte = irqMask_reg;
			default: rdByte = 8'h00;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			wbAck <= 1'b0;
			wbDatR <= '0;
		end
		else
		begin
			wbAck <= req;
			if (req && !wbWe)
				wbDatR <= {24'h000000, rdByte};
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			diagPort <= '0;
		else
			diagPort <= linkSel_reg; // [R1]
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sticky_hold_a: assert property (@(posedge clk) disable iff (!rstn) // [R3]
		anomaly_reg.icpErr && !rdAnomaly |=> anomaly_reg.icpErr)
		else $error("error flag dropped without a read");
	read_clear_a: assert property (@(posedge clk) disable iff (!rstn) // [R2]
		rdAnomaly && anomalyHit == '0 |=> anomaly_reg == '0)
		else $error("anomaly flags not cleared by read");
	read_value_a: assert property (@(posedge clk) disable iff (!rstn) // [R17]
		rdAnomaly |=> wbDatR[7:0] == $past(anomaly_reg) && wbAck)
		else $error("read did not return pre-read flags");
	event_kept_a: assert property (@(posedge clk) disable iff (!rstn) // [R17]
		rdAnomaly && linkEvent.port == linkSel_reg && linkEvent.events.icpMis
		|=> anomaly_reg.icpMis)
		else $error("event lost on clearing read");
	other_link_a: assert property (@(posedge clk) disable iff (!rstn) // [R1]
		linkEvent.port != linkSel_reg && !anomaly_reg.unexpLid |=> !anomaly_reg.unexpLid)
		else $error("flag set from unselected link");
	label_set_a: assert property (@(posedge clk) disable iff (!rstn) // [R4]
		linkEvent.port == linkSel_reg && linkEvent.events.unexpLabel |=> anomaly_reg.unexpLabel)
		else $error("label flag not latched");
	probe_value_a: assert property (@(posedge clk) disable iff (!rstn) // [R8]
		req |=> probe_reg == ^$past(wbAdr[11:2]))
		else $error("probe bit wrong");
	scratch_keep_a: assert property (@(posedge clk) disable iff (!rstn) // [R9]
		wrEn && idx == idt_pkg::IDX_SCRATCH |=> ##1 scratch_reg == $past(wrByte, 2))
		else $error("scratch not stored");
	index_zero_a: assert property (@(posedge clk) disable iff (!rstn) // [R14]
		timIndex_reg[5:4] == 2'h0)
		else $error("reserved index bits set");
	ack_once_a: assert property (@(posedge clk) disable iff (!rstn) // [R10]
		wbAck |=> !wbAck)
		else $error("ack held two cycles");
	err_set_a: assert property (@(posedge clk) disable iff (!rstn) // [R3]
		linkEvent.port == linkSel_reg && linkEvent.events.icpErr |=> anomaly_reg.icpErr)
		else $error("error flag not latched");
	lid_set_a: assert property (@(posedge clk) disable iff (!rstn) // [R5]
		linkEvent.port == linkSel_reg && linkEvent.events.unexpLid |=> anomaly_reg.unexpLid)
		else $error("link id flag not latched");
	group_id_set_a: assert property (@(posedge clk) disable iff (!rstn) // [R5]
		linkEvent.port == linkSel_reg && linkEvent.events.unexpGroupId |=> anomaly_reg.unexpGroupId)
		else $error("group id flag not latched");
	m_value_set_a: assert property (@(posedge clk) disable iff (!rstn) // [R6]
		linkEvent.port == linkSel_reg && linkEvent.events.unexpM |=> anomaly_reg.unexpM)
		else $error("frame length flag not latched");
	mis_set_a: assert property (@(posedge clk) disable iff (!rstn) // [R7]
		linkEvent.port == linkSel_reg && linkEvent.events.icpMis |=> anomaly_reg.icpMis)
		else $error("missing cell flag not latched");
	flags_ro_a: assert property (@(posedge clk) disable iff (!rstn) // [R2]
		wrEn && idx == idt_pkg::IDX_ANOMALY |=> anomaly_reg == ($past(anomaly_reg) | $past(anomalyHit)))
		else $error("anomaly flags changed by a write");

	// ------------------------------------------------------------
	// Checks on probe, scratch and link select
	// ------------------------------------------------------------
	probe_idle_a: assert property (@(posedge clk) disable iff (!rstn) // [R18]
		!req |=> probe_reg == $past(probe_reg))
		else $error("probe changed without an access");
	scratch_idle_a: assert property (@(posedge clk) disable iff (!rstn) // [R9]
		!(wrEn && idx == idt_pkg::IDX_SCRATCH) |=> scratch_reg == $past(scratch_reg))
		else $error("scratch changed without a write");
	link_sel_a: assert property (@(posedge clk) disable iff (!rstn) // [R15]
		wrEn && idx == idt_pkg::IDX_LINK_SEL
		|=> linkSel_reg == $past(wrByte[idt_pkg::LINK_MSB:0]))
		else $error("link select not stored");
	diag_port_a: assert property (@(posedge clk) disable iff (!rstn) // [R1]
		rstn |=> diagPort == $past(linkSel_reg))
		else $error("diagnostic port does not follow link select");

	// ------------------------------------------------------------
	// Checks on the timing selection
	// ------------------------------------------------------------
	index_keep_a: assert property (@(posedge clk) disable iff (!rstn) // [R10]
		!(wrEn && idx == idt_pkg::IDX_TIM_INDEX) |=> timIndex_reg == $past(timIndex_reg))
		else $error("index changed without a write");
	rx_src_set_a: assert property (@(posedge clk) disable iff (!rstn) // [R16]
		wrTimData && timType == idt_pkg::TIM_RX_REF && srcByte <= idt_pkg::SRC_REFCLK
		|=> rxGroupSrc[$past(timId)] == $past(srcByte))
		else $error("receive source not stored");
	rx_src_range_a: assert property (@(posedge clk) disable iff (!rstn) // [R16]
		wrTimData && timType == idt_pkg::TIM_RX_REF && srcByte > idt_pkg::SRC_REFCLK
		|=> rxGroupSrc[$past(timId)] == $past(rxGroupSrc[timId]))
		else $error("out of range receive source stored");
	tx_src_set_a: assert property (@(posedge clk) disable iff (!rstn) // [R16]
		wrTimData && timType == idt_pkg::TIM_TX_REF && srcByte <= idt_pkg::SRC_REFCLK
		|=> txGroupSrc[$past(timId)] == $past(srcByte))
		else $error("transmit source not stored");
	trl_src_set_a: assert property (@(posedge clk) disable iff (!rstn) // [R13]
		wrTimData && timType == idt_pkg::TIM_TRL_OUT && timId <= idt_pkg::TRL_MAX
		&& srcByte <= idt_pkg::SRC_8K |=> trlOutSrc[$past(timId[0])] == $past(srcByte))
		else $error("output pin source not stored");
	trl_id_range_a: assert property (@(posedge clk) disable iff (!rstn) // [R13]
		wrTimData && timType == idt_pkg::TIM_TRL_OUT && timId > idt_pkg::TRL_MAX
		|=> trlOutSrc[0] == $past(trlOutSrc[0]) && trlOutSrc[1] == $past(trlOutSrc[1]))
		else $error("output pin source changed by a bad id");
	clk_div_set_a: assert property (@(posedge clk) disable iff (!rstn) // [R12]
		wrTimData && timType == idt_pkg::TIM_CLK_DIV
		|=> groupClkDiv[$past(timId)] == $past(wrByte[idt_pkg::TIM_ID_MSB:0]))
		else $error("clock divisor not stored");
	tim_ack_a: assert property (@(posedge clk) disable iff (!rstn) // [R10]
		wrTimData |=> wbAck)
		else $error("timing data write not acknowledged");

endmodule

// [tb/idt_host_model.sv]
// Purpose: Host processor model that runs classic Wishbone single cycles.
// Assumes: Slave answers with a one-cycle ack.
// Notes: A wait that runs out of its bound sets timedOut.
module idt_host_model
(
	// Clock
	input wire logic clk,
	// Wishbone master
	output logic wbCyc,
	output logic wbStb,
	output logic wbWe,
	output logic [idt_pkg::ADDR_W-1:0] wbAdr,
	output logic [3:0] wbSel,
	output logic [31:0] wbDatW,
	input wire logic [31:0] wbDatR,
	input wire logic wbAck
);
	timeunit 1ns;
	timeprecision 1ns;
	logic timedOut = 1'b0;
	initial
	begin
		{wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW} = '0;
	end
	// Index writes keep the reserved bits at zero.
	task automatic access(input logic we, input logic [11:0] idx, input logic [7:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbSel <= 4'h1;
		wbAdr <= {idx, 2'b00};
		wbDatW <= {24'h0, (idx == idt_pkg::IDX_TIM_INDEX) ? (d & idt_pkg::TIM_INDEX_MASK) : d};
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wbAck !== 1'b1 && n < 50);
		timedOut = (wbAck !== 1'b1);
		q = wbDatR;
		{wbCyc, wbStb, wbWe} <= 3'b000;
		wbDatW <= ~wbDatW;
	endtask
endmodule

// [tb/tb.sv]
// Purpose: Self-checking bench for the diagnostic and timing select registers.
// Assumes: Host model runs the bus; bench drives anomaly events.
// Notes: Random values use a fixed seed.
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin errors++; \
	$display("[ERR] %s exp %h got %h", n, e, s); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic wbCyc, wbStb, wbWe, wbAck, irq;
	logic [idt_pkg::ADDR_W-1:0] wbAdr;
	logic [3:0] wbSel;
	logic [31:0] wbDatW, wbDatR, q;
	idt_pkg::idt_link_event_s linkEvent = '0;
	logic [4:0] diagPort, p;
	logic [5:0] rxGroupSrc [idt_pkg::NUM_GROUPS];
	logic [5:0] txGroupSrc [idt_pkg::NUM_GROUPS];
	logic [3:0] groupClkDiv [idt_pkg::NUM_GROUPS];
	logic [5:0] trlOutSrc [idt_pkg::NUM_TRL];
	logic [11:0] a;
	logic [7:0] d;
	logic [3:0] id;
	logic [1:0] t;
	logic [7:0] e8;
	logic [5:0] trlExp [idt_pkg::NUM_TRL] = '{default: '0};
	int errors = 0;
	int total_checks = 0;
	idt_diag_timing_regs i_dut (.clk(clk), .rstn(rstn), .wbCyc(wbCyc), .wbStb(wbStb),
		.wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR),
		.wbAck(wbAck), .linkEvent(linkEvent), .diagPort(diagPort), .rxGroupSrc(rxGroupSrc),
		.txGroupSrc(txGroupSrc), .groupClkDiv(groupClkDiv), .trlOutSrc(trlOutSrc), .irq(irq));
	idt_host_model i_host (.clk(clk), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
		.wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck));
	initial
	begin
		forever #25 clk = ~clk;
	end
	// ------------------------------------------------------------
	// Bus and event tasks
	// ------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic rd(input logic w, input logic [11:0] i, input logic [7:0] v);
		i_host.access(w, i, v, q);
		if (i_host.timedOut)
		begin
			errors++;
			conclude();
		end
	endtask
	task automatic chkrd(input string n, input logic [11:0] i, input logic [31:0] e);
		rd(1'b0, i, 8'h00);
		`CHK(n, e, q)
	endtask
	task automatic pulse(input logic [4:0] pt, input logic [7:0] ev);
		@(posedge clk);
		linkEvent <= idt_pkg::idt_link_event_s'({pt, ev});
		@(posedge clk);
		linkEvent <= '0;
	endtask
	function automatic logic probe_expect(input logic [11:0] ia);
		return ^ia[9:0];
	endfunction
	// The closing 0x3f write is refused as a source but is a divisor of 0xf.
	function automatic logic [7:0] tim_expect(input logic [1:0] ty, input logic [7:0] dv);
		return (ty == 2'd3) ? 8'h0f : {2'h0, dv[5:0]};
	endfunction
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		void'($urandom(49));
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		chkrd("probeRst", idt_pkg::IDX_ADDR_PROBE, 32'h0);
		chkrd("scratchRst", idt_pkg::IDX_SCRATCH, 32'h0);
		chkrd("anomRst", idt_pkg::IDX_ANOMALY, 32'h0);
		for (int k = 0; k < 6; k++)
		begin
			d = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom);
			rd(1'b1, idt_pkg::IDX_SCRATCH, d);
			chkrd("scratch", idt_pkg::IDX_SCRATCH, {24'h0, d});
			a = (k == 0) ? 12'h001 : (k == 1) ? 12'h003 : 12'($urandom % 12'h400);
			chkrd("unmapped", a, 32'h0);
			chkrd("probe", idt_pkg::IDX_ADDR_PROBE, {31'h0, probe_expect(a)});
		end
		$display("test scratch_probe done");
		p = 5'($urandom);
		rd(1'b1, idt_pkg::IDX_LINK_SEL, {3'h0, p});
		chkrd("linkSel", idt_pkg::IDX_LINK_SEL, {27'h0, p});
		`CHK("diagPort", p, diagPort)
		for (int b = 0; b < 8; b++)
		begin
			pulse(p, 8'h01 << b);
			pulse(p ^ 5'h01, 8'hff);
			chkrd("anomaly", idt_pkg::IDX_ANOMALY, 32'h1 << b);
			chkrd("anomClr", idt_pkg::IDX_ANOMALY, 32'h0);
		end
		pulse(p, 8'h81);
		rd(1'b1, idt_pkg::IDX_ANOMALY, 8'h00);
		chkrd("anomRO", idt_pkg::IDX_ANOMALY, 32'h81);
		fork
			chkrd("anomRace", idt_pkg::IDX_ANOMALY, 32'h0);
			pulse(p, 8'h40);
		join
		chkrd("anomKept", idt_pkg::IDX_ANOMALY, 32'h40);
		$display("test anomaly done");
		for (int k = 0; k < 4; k++)
		begin
			t = 2'(k);
			id = (t == 2'd2) ? 4'($urandom % 2) : 4'($urandom);
			d = (t == 2'd3) ? 8'($urandom % 16) : 8'($urandom % 34);
			e8 = tim_expect(t, d);
			if (t == 2'd2)
				trlExp[id[0]] = e8[5:0];
			rd(1'b1, idt_pkg::IDX_TIM_INDEX, {t, 2'b11, id});
			chkrd("index", idt_pkg::IDX_TIM_INDEX, {24'h0, t, 2'b00, id});
			rd(1'b1, idt_pkg::IDX_TIM_DATA, d);
			rd(1'b1, idt_pkg::IDX_TIM_DATA, 8'h3f);
			chkrd("timData", idt_pkg::IDX_TIM_DATA, {24'h0, e8});
			case (t)
				2'd0: `CHK("rxSrc", e8[5:0], rxGroupSrc[id])
				2'd1: `CHK("txSrc", e8[5:0], txGroupSrc[id])
				2'd2: `CHK("trlSrc", e8[5:0], trlOutSrc[id[0]])
				default: `CHK("clkDiv", e8[3:0], groupClkDiv[id])
			endcase
		end
		rd(1'b1, idt_pkg::IDX_TIM_INDEX, 8'h85);
		rd(1'b1, idt_pkg::IDX_TIM_DATA, 8'h05);
		`CHK("trl0", trlExp[0], trlOutSrc[0])
		`CHK("trl1", trlExp[1], trlOutSrc[1])
		$display("test timing done");
		rd(1'b1, idt_pkg::IDX_IRQ_STATUS, 8'hff);
		rd(1'b1, idt_pkg::IDX_IRQ_MASK, 8'h01);
		pulse(p, 8'h02);
		chkrd("irqStat", idt_pkg::IDX_IRQ_STATUS, 32'h02);
		`CHK("irqMasked", 1'b0, irq)
		pulse(p, 8'h01);
		chkrd("irqStat", idt_pkg::IDX_IRQ_STATUS, 32'h03);
		`CHK("irqHigh", 1'b1, irq)
		rd(1'b1, idt_pkg::IDX_IRQ_STATUS, 8'h01);
		chkrd("irqStat", idt_pkg::IDX_IRQ_STATUS, 32'h02);
		`CHK("irqLow", 1'b0, irq)
		$display("test irq done");
		conclude();
	end
	initial
	begin
		repeat (90000) @(posedge clk);
		errors++;
		conclude();
	end
endmodule
